// ==== src/pfd_pin_mux.sv ====
// Contract
// - First three PD pins can become I2C data, clock, active-low interrupt.
// - After reset every PD pin is an input with weak pull-down.
// - Only the PD controller drives or samples PD pins; never the bus.
// - Main bit 0 defaults to transmit data out, bit 1 receive in.
// - Main bits 2,4 are RTS/DTR outputs; bits 3,5 CTS/DSR inputs.
// - Main bits 6 and 7 default to carrier-detect and ring inputs.
// - With remote wake enabled and bit-bang mode off, ring going low resumes a suspended host.
// - Each aux pin function comes from the configuration memory.
// - Without configuration memory, aux pins except 7 are pulled-up inputs.
// - Without configuration memory, aux pin 7 is a pulled-down input.
// - Inputs pull up, or pull gently low in suspend or before USB configuration when option set.
// - Power enable goes low after configuration, high during suspend.
`timescale 1ns/1ps
module pfd_pin_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pfd_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Configuration memory loader
  input wire logic cfg_done,
  input wire logic cfg_fitted,
  input wire pfd_pkg::pfd_cfg_t cfg_data,
  // USB state
  input wire logic usb_configured,
  input wire logic usb_suspend,
  output logic usb_resume_req,
  output logic power_enable_n,
  // PD controller side
  input wire logic pd_i2c_en,
  input wire logic [pfd_pkg::PD_PINS-1:0] pd_gp_drive,
  input wire logic [pfd_pkg::PD_PINS-1:0] pd_gp_dir,
  input wire logic pd_sda_drive_low,
  input wire logic pd_scl_drive_low,
  input wire logic pd_int,
  output logic [pfd_pkg::PD_PINS-1:0] pd_gp_sample,
  // UART side
  input wire logic uart_txd,
  input wire logic uart_rts_n,
  input wire logic uart_dtr_n,
  input wire logic uart_txden,
  input wire logic uart_tx_act,
  input wire logic uart_rx_act,
  output logic uart_rxd,
  output logic uart_cts_n,
  output logic uart_dsr_n,
  output logic uart_dcd_n,
  output logic uart_ri_n,
  // PD general pins
  input wire logic [pfd_pkg::PD_PINS-1:0] pd_gp_pin_in,
  output logic [pfd_pkg::PD_PINS-1:0] pd_gp_pin_out,
  output logic [pfd_pkg::PD_PINS-1:0] pd_gp_pin_oe,
  output logic [pfd_pkg::PD_PINS-1:0] pd_gp_pin_pull_dn,
  // Main bus pins
  input wire logic [pfd_pkg::MAIN_PINS-1:0] main_bus_in,
  output logic [pfd_pkg::MAIN_PINS-1:0] main_bus_out,
  output logic [pfd_pkg::MAIN_PINS-1:0] main_bus_oe,
  output logic [pfd_pkg::MAIN_PINS-1:0] main_bus_pull_up,
  output logic [pfd_pkg::MAIN_PINS-1:0] main_bus_pull_dn,
  // Aux bus pins
  input wire logic [pfd_pkg::AUX_PINS-1:0] aux_bus_in,
  output logic [pfd_pkg::AUX_PINS-1:0] aux_bus_out,
  output logic [pfd_pkg::AUX_PINS-1:0] aux_bus_oe,
  output logic [pfd_pkg::AUX_PINS-1:0] aux_bus_pull_up,
  output logic [pfd_pkg::AUX_PINS-1:0] aux_bus_pull_dn
);

  localparam int PD = pfd_pkg::PD_PINS;
  localparam int MN = pfd_pkg::MAIN_PINS;
  localparam int AX = pfd_pkg::AUX_PINS;

  // ---------------------------------------------------------------
  // Configuration state
  // ---------------------------------------------------------------
  logic cfg_loaded;
  logic fitted;
  pfd_pkg::pfd_cfg_t cfg_q;

  // Defaults hold until the loader reports a finished read.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_loaded <= 1'b0;
      fitted <= 1'b0;
      cfg_q <= '0;
    end else if (cfg_done && !cfg_loaded) begin
      cfg_loaded <= 1'b1;
      fitted <= cfg_fitted;
      if (cfg_fitted) begin
        cfg_q <= cfg_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic bb_mode;
  logic [MN-1:0] main_bb_out;
  logic [MN-1:0] main_bb_dir;
  logic [AX-1:0] aux_bb_out;
  logic [AX-1:0] aux_bb_dir;
  logic wb_req;
  logic wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  // Writes take effect at the edge that raises ack.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bb_mode <= 1'b0;
      main_bb_out <= pfd_pkg::MAIN_BB_OUT_RST;
      main_bb_dir <= pfd_pkg::MAIN_BB_DIR_RST;
      aux_bb_out <= pfd_pkg::AUX_BB_OUT_RST;
      aux_bb_dir <= pfd_pkg::AUX_BB_DIR_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        pfd_pkg::REG_MAIN_CTRL: begin
          if (wb_sel_i[0]) begin
            bb_mode <= wb_dat_i[pfd_pkg::CTRL_BB_MODE];
          end
        end
        pfd_pkg::REG_MAIN_BB: begin
          if (wb_sel_i[0]) begin
            main_bb_out <= wb_dat_i[MN-1:0];
          end
          if (wb_sel_i[1]) begin
            main_bb_dir <= wb_dat_i[pfd_pkg::MAIN_BB_DIR_LSB +: MN];
          end
        end
        pfd_pkg::REG_AUX_BB: begin
          if (wb_sel_i[0]) begin
            aux_bb_out[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            aux_bb_out[AX-1:8] <= wb_dat_i[AX-1:8];
          end
          if (wb_sel_i[2]) begin
            aux_bb_dir[7:0] <= wb_dat_i[pfd_pkg::AUX_BB_DIR_LSB +: 8];
          end
          if (wb_sel_i[3]) begin
            aux_bb_dir[AX-1:8] <= wb_dat_i[24 +: AX-8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Reads of unmapped offsets return zero; every request is acked.
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      pfd_pkg::REG_STATUS: begin
        next_rdata[pfd_pkg::STAT_CFG_LOADED] = cfg_loaded;
        next_rdata[pfd_pkg::STAT_FITTED] = fitted;
        next_rdata[pfd_pkg::STAT_SUSPEND] = usb_suspend;
        next_rdata[pfd_pkg::STAT_POWER_ENABLE_N_N] = power_enable_n;
        next_rdata[pfd_pkg::STAT_PD_I2C] = pd_i2c_en;
      end
      pfd_pkg::REG_AUX_CFG_LO: begin
        next_rdata = cfg_q.aux_func[7:0];
      end
      pfd_pkg::REG_AUX_CFG_HI: begin
        next_rdata[7:0] = cfg_q.aux_func[AX-1:8];
        next_rdata[pfd_pkg::CFG_HI_WAKE] = cfg_q.remote_wake_en;
        next_rdata[pfd_pkg::CFG_HI_PULL_LOW] = cfg_q.suspend_pull_low;
      end
      pfd_pkg::REG_MAIN_CTRL: begin
        next_rdata[pfd_pkg::CTRL_BB_MODE] = bb_mode;
      end
      pfd_pkg::REG_MAIN_BB: begin
        next_rdata[MN-1:0] = main_bb_out;
        next_rdata[pfd_pkg::MAIN_BB_DIR_LSB +: MN] = main_bb_dir;
      end
      pfd_pkg::REG_AUX_BB: begin
        next_rdata[AX-1:0] = aux_bb_out;
        next_rdata[pfd_pkg::AUX_BB_DIR_LSB +: AX] = aux_bb_dir;
      end
      pfd_pkg::REG_PIN_IN: begin
        next_rdata[MN-1:0] = main_bus_in;
        next_rdata[pfd_pkg::PIN_IN_AUX_LSB +: AX] = aux_bus_in;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? next_rdata : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // USB power and wake
  // ---------------------------------------------------------------
  logic ri_prev;
  logic suspend_pull;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_enable_n <= 1'b1;
    end else begin
      power_enable_n <= !usb_configured || usb_suspend;
    end
  end

  // Ring is sampled directly; pins are synchronous to clk.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ri_prev <= 1'b1;
      usb_resume_req <= 1'b0;
    end else begin
      ri_prev <= main_bus_in[pfd_pkg::MAIN_RI];
      usb_resume_req <= cfg_q.remote_wake_en && usb_suspend && !bb_mode &&
                        ri_prev && !main_bus_in[pfd_pkg::MAIN_RI];
    end
  end

  // Power enable stands high both in suspend and before configuration.
  assign suspend_pull = cfg_q.suspend_pull_low && power_enable_n;

  // ---------------------------------------------------------------
  // PD general pins
  // ---------------------------------------------------------------
  logic [PD-1:0] next_pd_out;
  logic [PD-1:0] next_pd_oe;
  logic [PD-1:0] next_pd_pull;

  // Only the PD controller ports reach these pins.
  always_comb begin
    next_pd_out = pd_gp_drive;
    next_pd_oe = pd_gp_dir;
    next_pd_pull = ~pd_gp_dir;
    if (pd_i2c_en) begin
      next_pd_out[pfd_pkg::PD_SDA] = 1'b0;
      next_pd_oe[pfd_pkg::PD_SDA] = pd_sda_drive_low;
      next_pd_pull[pfd_pkg::PD_SDA] = 1'b0;
      next_pd_out[pfd_pkg::PD_SCL] = 1'b0;
      next_pd_oe[pfd_pkg::PD_SCL] = pd_scl_drive_low;
      next_pd_pull[pfd_pkg::PD_SCL] = 1'b0;
      next_pd_out[pfd_pkg::PD_INT] = ~pd_int;
      next_pd_oe[pfd_pkg::PD_INT] = 1'b1;
      next_pd_pull[pfd_pkg::PD_INT] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pd_gp_pin_out <= '0;
      pd_gp_pin_oe <= '0;
      pd_gp_pin_pull_dn <= '1;
      pd_gp_sample <= '0;
    end else begin
      pd_gp_pin_out <= next_pd_out;
      pd_gp_pin_oe <= next_pd_oe;
      pd_gp_pin_pull_dn <= next_pd_pull;
      pd_gp_sample <= pd_gp_pin_in;
    end
  end

  // ---------------------------------------------------------------
  // Main bus pins
  // ---------------------------------------------------------------
  logic [MN-1:0] next_main_out;
  logic [MN-1:0] next_main_oe;

  always_comb begin
    if (bb_mode) begin
      next_main_out = main_bb_out;
      next_main_oe = main_bb_dir;
    end else begin
      next_main_out = '0;
      next_main_oe = pfd_pkg::MAIN_UART_DIR;
      next_main_out[pfd_pkg::MAIN_TXD] = uart_txd;
      next_main_out[pfd_pkg::MAIN_RTS] = uart_rts_n;
      next_main_out[pfd_pkg::MAIN_DTR] = uart_dtr_n;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      main_bus_out <= pfd_pkg::MAIN_UART_OUT;
      main_bus_oe <= pfd_pkg::MAIN_UART_DIR;
      main_bus_pull_up <= ~pfd_pkg::MAIN_UART_DIR;
      main_bus_pull_dn <= '0;
    end else begin
      main_bus_out <= next_main_out;
      main_bus_oe <= next_main_oe;
      main_bus_pull_up <= suspend_pull ? '0 : ~next_main_oe;
      main_bus_pull_dn <= suspend_pull ? ~next_main_oe : '0;
    end
  end

  // Receive-side UART lines idle high while the pins are in bit-bang use.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      uart_rxd <= 1'b1;
      uart_cts_n <= 1'b1;
      uart_dsr_n <= 1'b1;
      uart_dcd_n <= 1'b1;
      uart_ri_n <= 1'b1;
    end else begin
      uart_rxd <= bb_mode || main_bus_in[pfd_pkg::MAIN_RXD];
      uart_cts_n <= bb_mode || main_bus_in[pfd_pkg::MAIN_CTS];
      uart_dsr_n <= bb_mode || main_bus_in[pfd_pkg::MAIN_DSR];
      uart_dcd_n <= bb_mode || main_bus_in[pfd_pkg::MAIN_DCD];
      uart_ri_n <= bb_mode || main_bus_in[pfd_pkg::MAIN_RI];
    end
  end

  // ---------------------------------------------------------------
  // Aux bus pins
  // ---------------------------------------------------------------
  pfd_pkg::pfd_aux_ctx_t aux_ctx;
  pfd_pkg::pfd_pad_t aux_pad [AX];

  assign aux_ctx.txden = uart_txden;
  assign aux_ctx.power_enable_n = power_enable_n;
  assign aux_ctx.tx_act = uart_tx_act;
  assign aux_ctx.rx_act = uart_rx_act;
  assign aux_ctx.suspended = usb_suspend;
  assign aux_ctx.pull_low = suspend_pull;

  for (genvar i = 0; i < AX; i++) begin : g_aux
    pfd_aux_cell u_cell (
      .func(cfg_q.aux_func[i]),
      .ctx(aux_ctx),
      .bb_out(aux_bb_out[i]),
      .bb_dir(aux_bb_dir[i]),
      .pad(aux_pad[i])
    );

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        aux_bus_out[i] <= 1'b0;
        aux_bus_oe[i] <= 1'b0;
        aux_bus_pull_up[i] <= pfd_pkg::AUX_PU_DFLT[i];
        aux_bus_pull_dn[i] <= pfd_pkg::AUX_PD_DFLT[i];
      end else if (cfg_loaded && fitted) begin
        aux_bus_out[i] <= aux_pad[i].out;
        aux_bus_oe[i] <= aux_pad[i].oe;
        aux_bus_pull_up[i] <= aux_pad[i].pull_up;
        aux_bus_pull_dn[i] <= aux_pad[i].pull_dn;
      end else begin
        aux_bus_out[i] <= 1'b0;
        aux_bus_oe[i] <= 1'b0;
        aux_bus_pull_up[i] <= pfd_pkg::AUX_PU_DFLT[i];
        aux_bus_pull_dn[i] <= pfd_pkg::AUX_PD_DFLT[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_i2c_int_pin: assert property (@(posedge clk) disable iff (reset)
    pd_i2c_en && pd_int |=> pd_gp_pin_oe[2] && !pd_gp_pin_out[2])
    else $error("PD interrupt pin not driven low");

  chk_pd_default: assert property (@(posedge clk) disable iff (reset)
    !pd_i2c_en && pd_gp_dir == '0 |=>
      pd_gp_pin_oe == '0 && pd_gp_pin_pull_dn == '1)
    else $error("PD pin not pulled-down input");

  chk_pd_source: assert property (@(posedge clk) disable iff (reset)
    !pd_i2c_en |=> pd_gp_pin_out == $past(pd_gp_drive) &&
      pd_gp_pin_oe == $past(pd_gp_dir))
    else $error("PD pin driven by another source");

  chk_main_uart: assert property (@(posedge clk) disable iff (reset)
    !bb_mode |=> main_bus_oe == pfd_pkg::MAIN_UART_DIR &&
      main_bus_out[0] == $past(uart_txd) &&
      main_bus_out[2] == $past(uart_rts_n))
    else $error("Main bus not in UART default");

  chk_modem_in: assert property (@(posedge clk) disable iff (reset)
    !bb_mode && !main_bus_in[7] |=> !main_bus_oe[7] && !main_bus_oe[6] &&
      !uart_ri_n)
    else $error("Ring input not routed");

  chk_ring_wake: assert property (@(posedge clk) disable iff (reset)
    main_bus_in[7] ##1 (!main_bus_in[7] && cfg_q.remote_wake_en &&
      usb_suspend && !bb_mode) |=> usb_resume_req ##1
      !usb_resume_req)
    else $error("Ring did not request resume");

  chk_aux_default: assert property (@(posedge clk) disable iff (reset)
    !cfg_loaded ##1 1'b1 |-> aux_bus_oe == '0 &&
      aux_bus_pull_up == pfd_pkg::AUX_PU_DFLT &&
      aux_bus_pull_dn == pfd_pkg::AUX_PD_DFLT)
    else $error("Aux pins left default early");

  chk_aux_drive0: assert property (@(posedge clk) disable iff (reset)
    cfg_loaded && fitted && cfg_q.aux_func[1] == pfd_pkg::PFD_FN_DRIVE0
      |=> aux_bus_oe[1] && !aux_bus_out[1])
    else $error("Aux function not applied");

  chk_suspend_pull: assert property (@(posedge clk) disable iff (reset)
    cfg_q.suspend_pull_low && power_enable_n && !bb_mode |=>
      !main_bus_pull_up[1] && main_bus_pull_dn[1])
    else $error("Suspend pull-low not applied");

  chk_power_en: assert property (@(posedge clk) disable iff (reset)
    usb_configured && !usb_suspend ##1 usb_suspend |-> !power_enable_n ##1
      power_enable_n)
    else $error("Power enable wrong around suspend");

endmodule

// ==== common/pfd_pkg.sv ====
package pfd_pkg;

  // ---------------------------------------------------------------
  // Pin counts and bus widths
  // ---------------------------------------------------------------
  localparam int PD_PINS = 8;
  localparam int MAIN_PINS = 8;
  localparam int AUX_PINS = 10;
  localparam int FUNC_W = 4;
  localparam int ADR_W = 8;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_AUX_CFG_LO = 8'h04;
  localparam logic [7:0] REG_AUX_CFG_HI = 8'h08;
  localparam logic [7:0] REG_MAIN_CTRL = 8'h0C;
  localparam logic [7:0] REG_MAIN_BB = 8'h10;
  localparam logic [7:0] REG_AUX_BB = 8'h14;
  localparam logic [7:0] REG_PIN_IN = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STAT_CFG_LOADED = 0;
  localparam int STAT_FITTED = 1;
  localparam int STAT_SUSPEND = 2;
  localparam int STAT_POWER_ENABLE_N_N = 3;
  localparam int STAT_PD_I2C = 4;
  localparam int CTRL_BB_MODE = 0;
  localparam int MAIN_BB_DIR_LSB = 8;
  localparam int AUX_BB_DIR_LSB = 16;
  localparam int PIN_IN_AUX_LSB = 16;
  localparam int CFG_HI_WAKE = 8;
  localparam int CFG_HI_PULL_LOW = 9;
  localparam int MAIN_TXD = 0;
  localparam int MAIN_RXD = 1;
  localparam int MAIN_RTS = 2;
  localparam int MAIN_CTS = 3;
  localparam int MAIN_DTR = 4;
  localparam int MAIN_DSR = 5;
  localparam int MAIN_DCD = 6;
  localparam int MAIN_RI = 7;
  localparam int PD_SDA = 0;
  localparam int PD_SCL = 1;
  localparam int PD_INT = 2;
  localparam int AUX_PD_PIN = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MAIN_UART_DIR = 8'h15;
  localparam logic [7:0] MAIN_UART_OUT = 8'h15;
  localparam logic [7:0] MAIN_BB_OUT_RST = 8'h00;
  localparam logic [7:0] MAIN_BB_DIR_RST = 8'h00;
  localparam logic [9:0] AUX_BB_OUT_RST = 10'h000;
  localparam logic [9:0] AUX_BB_DIR_RST = 10'h000;
  localparam logic [9:0] AUX_PU_DFLT = 10'h37F;
  localparam logic [9:0] AUX_PD_DFLT = 10'h080;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PFD_FN_HIZ_PU = 4'h0,
    PFD_FN_HIZ_PD = 4'h1,
    PFD_FN_DRIVE0 = 4'h2,
    PFD_FN_DRIVE1 = 4'h3,
    PFD_FN_TXDEN = 4'h4,
    PFD_FN_POWER_ENABLE_N = 4'h5,
    PFD_FN_TXLED = 4'h6,
    PFD_FN_RXLED = 4'h7,
    PFD_FN_TXRXLED = 4'h8,
    PFD_FN_SLEEP = 4'h9,
    PFD_FN_IOMODE = 4'hA
  } pfd_aux_func_t;

  typedef struct packed {
    logic [AUX_PINS-1:0][FUNC_W-1:0] aux_func;
    logic remote_wake_en;
    logic suspend_pull_low;
  } pfd_cfg_t;

  typedef struct packed {
    logic txden;
    logic power_enable_n;
    logic tx_act;
    logic rx_act;
    logic suspended;
    logic pull_low;
  } pfd_aux_ctx_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_dn;
  } pfd_pad_t;

endpackage

// ==== src/pfd_aux_cell.sv ====
`timescale 1ns/1ps
module pfd_aux_cell (
  // Function selection
  input wire logic [3:0] func,
  input wire pfd_pkg::pfd_aux_ctx_t ctx,
  // Bit-bang values for this pin
  input wire logic bb_out,
  input wire logic bb_dir,
  // Resulting pad controls
  output pfd_pkg::pfd_pad_t pad
);

  // Inputs pull up, or pull gently low in suspend or before USB configuration when that option is on.
  always_comb begin
    pad = '0;
    pad.pull_up = ~ctx.pull_low;
    pad.pull_dn = ctx.pull_low;
    case (func)
      pfd_pkg::PFD_FN_HIZ_PU: begin
      end
      pfd_pkg::PFD_FN_HIZ_PD: begin
        pad.pull_up = 1'b0;
        pad.pull_dn = 1'b1;
      end
      pfd_pkg::PFD_FN_DRIVE0: begin
        pad.oe = 1'b1;
        pad.out = 1'b0;
      end
      pfd_pkg::PFD_FN_DRIVE1: begin
        pad.oe = 1'b1;
        pad.out = 1'b1;
      end
      pfd_pkg::PFD_FN_TXDEN: begin
        pad.oe = 1'b1;
        pad.out = ctx.txden;
      end
      pfd_pkg::PFD_FN_POWER_ENABLE_N: begin
        pad.oe = 1'b1;
        pad.out = ctx.power_enable_n;
      end
      pfd_pkg::PFD_FN_TXLED: begin
        pad.oe = 1'b1;
        pad.out = ~ctx.tx_act;
      end
      pfd_pkg::PFD_FN_RXLED: begin
        pad.oe = 1'b1;
        pad.out = ~ctx.rx_act;
      end
      pfd_pkg::PFD_FN_TXRXLED: begin
        pad.oe = 1'b1;
        pad.out = ~(ctx.tx_act | ctx.rx_act);
      end
      pfd_pkg::PFD_FN_SLEEP: begin
        pad.oe = 1'b1;
        pad.out = ~ctx.suspended;
      end
      pfd_pkg::PFD_FN_IOMODE: begin
        pad.oe = bb_dir;
        pad.out = bb_out;
      end
      default: begin
      end
    endcase
    // Driven pins carry no pull, so suspend pull-low only reaches inputs.
    if (pad.oe) begin
      pad.pull_up = 1'b0;
      pad.pull_dn = 1'b0;
    end
  end

endmodule

// ==== testbench/pfd_far_model.sv ====
`timescale 1ns/1ps
module pfd_far_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Commands from the bench
  input wire logic load,
  input wire logic ring,
  // Configuration memory loader
  output logic cfg_done,
  output logic cfg_fitted,
  output pfd_pkg::pfd_cfg_t cfg_data,
  // Modem ring line
  output logic ri_n
);
  logic [2:0] wait_cnt;

  // Each aux pin takes a different function, pin 7 pulls down.
  // Remote wake and suspend pull-low are both set.
  assign cfg_data = {40'h76184A9523, 1'h1, 1'h1};
  assign cfg_fitted = 1'h1;

  // The read takes a few cycles and reports done once.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_cnt <= 3'h0;
      cfg_done <= 1'h0;
    end else begin
      if (load && wait_cnt != 3'h7) wait_cnt <= wait_cnt + 3'h1;
      cfg_done <= load && (wait_cnt == 3'h4);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) ri_n <= 1'h1;
    else ri_n <= !ring;
  end
endmodule

// ==== testbench/pfd_pin_mux_tb.sv ====
`timescale 1ns/1ps
module pfd_pin_mux_tb;
  logic clk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = '0, pd_gp_drive = '0, pd_gp_dir = '0;
  logic [7:0] pd_gp_pin_in = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic usb_configured = 0, usb_suspend = 0, pd_i2c_en = 0, pd_int = 0;
  logic pd_sda_drive_low = 0, pd_scl_drive_low = 0, uart_txd = 1;
  logic uart_rts_n = 1, uart_dtr_n = 1, uart_txden = 0, uart_tx_act = 0;
  logic uart_rx_act = 0, load = 0, ring = 0, ri_n;
  logic [6:0] main_lo = 7'h7F;
  logic [9:0] aux_bus_in = '0, aux_bus_out, aux_bus_oe;
  logic [9:0] aux_bus_pull_up, aux_bus_pull_dn;
  wire logic [7:0] main_bus_in = {ri_n, main_lo};
  logic wb_ack_o, cfg_done, cfg_fitted, usb_resume_req, power_enable_n;
  logic uart_rxd, uart_cts_n, uart_dsr_n, uart_dcd_n, uart_ri_n;
  logic [7:0] pd_gp_sample, pd_gp_pin_out, pd_gp_pin_oe, pd_gp_pin_pull_dn;
  logic [7:0] main_bus_out, main_bus_oe, main_bus_pull_up, main_bus_pull_dn;
  pfd_pkg::pfd_cfg_t cfg_data;
  int bad_count = 0, n_checks = 0, cycles = 0, pulses;

  pfd_pin_mux u_dut (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cfg_done,
    .cfg_fitted, .cfg_data, .usb_configured, .usb_suspend,
    .usb_resume_req, .power_enable_n, .pd_i2c_en, .pd_gp_drive,
    .pd_gp_dir, .pd_sda_drive_low, .pd_scl_drive_low, .pd_int,
    .pd_gp_sample, .uart_txd, .uart_rts_n, .uart_dtr_n, .uart_txden,
    .uart_tx_act, .uart_rx_act, .uart_rxd, .uart_cts_n, .uart_dsr_n,
    .uart_dcd_n, .uart_ri_n, .pd_gp_pin_in, .pd_gp_pin_out,
    .pd_gp_pin_oe, .pd_gp_pin_pull_dn, .main_bus_in, .main_bus_out,
    .main_bus_oe, .main_bus_pull_up, .main_bus_pull_dn, .aux_bus_in,
    .aux_bus_out, .aux_bus_oe, .aux_bus_pull_up, .aux_bus_pull_dn);
  pfd_far_model u_far (.clk, .reset, .load, .ring, .cfg_done, .cfg_fitted,
    .cfg_data, .ri_n);

  initial forever #20 clk = ~clk;

  // The whole run needs under a hundred cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  // Counts resume pulses while the far side pulls the ring line low.
  task wake();
    pulses = 0;
    ring <= 1'h1;
    repeat (8) begin
      @(posedge clk);
      if (usb_resume_req === 1'h1) pulses++;
    end
    ring <= 1'h0;
    step(3);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    step(20);
    reset <= 1'h0;
    step(2);
    chk("pd oe", pd_gp_pin_oe, 8'h00);
    chk("pd pull", pd_gp_pin_pull_dn, 8'hFF);
    chk("main oe", main_bus_oe, 8'h15);
    chk("main pull", {main_bus_pull_up, main_bus_pull_dn}, 16'hEA00);
    chk("aux pu", aux_bus_pull_up, 10'h37F);
    chk("aux pd", {aux_bus_pull_dn, aux_bus_oe}, 20'h20000);
    uart_txd <= 1'h0;
    uart_dtr_n <= 1'h0;
    main_lo <= 7'h55;
    pd_gp_pin_in <= 8'h5A;
    pd_i2c_en <= 1'h1;
    pd_int <= 1'h1;
    pd_sda_drive_low <= 1'h1;
    pd_scl_drive_low <= 1'h1;
    pd_gp_dir <= 8'hF8;
    pd_gp_drive <= 8'hAF;
    step(2);
    chk("main out", main_bus_out & 8'h15, 8'h04);
    chk("uart in", {uart_rxd, uart_cts_n, uart_dsr_n, uart_dcd_n, uart_ri_n},
      5'h03);
    chk("pd oe i2c", pd_gp_pin_oe, 8'hFF);
    chk("pd out i2c", pd_gp_pin_out, 8'hA8);
    chk("pd sample", pd_gp_sample, 8'h5A);
    wb(1'h1, pfd_pkg::REG_MAIN_BB, 32'hFFFFFFFF);
    wb(1'h1, pfd_pkg::REG_AUX_BB, 32'h03EF03FF);
    wb(1'h0, pfd_pkg::REG_MAIN_BB, 32'h0);
    chk("main bb", q[15:0], 16'hFFFF);
    wb(1'h0, pfd_pkg::REG_AUX_BB, 32'h0);
    chk("aux bb", q, 32'h03EF03FF);
    wb(1'h1, pfd_pkg::REG_MAIN_CTRL, 32'h1);
    step(1);
    chk("bb pins", {main_bus_oe, main_bus_out}, 16'hFFFF);
    chk("bb uart", {uart_rxd, uart_cts_n, uart_dsr_n, uart_dcd_n, uart_ri_n},
      5'h1F);
    wb(1'h1, pfd_pkg::REG_MAIN_CTRL, 32'h0);
    chk("pd out bus", {pd_gp_pin_out, pd_gp_pin_oe}, 16'hA8FF);
    pd_i2c_en <= 1'h0;
    wb(1'h0, 8'h1C, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'h0, pfd_pkg::REG_STATUS, 32'h0);
    chk("status", q[4:0], 5'h08);
    chk("pd gp", {pd_gp_pin_out, pd_gp_pin_oe}, 16'hAFF8);
    load <= 1'h1;
    do step(1); while (cfg_done !== 1'h1);
    step(1);
    chk("aux early", aux_bus_pull_up, 10'h37F);
    step(1);
    chk("aux drv", {aux_bus_oe, aux_bus_out}, 20'hDBF5D);
    chk("aux pl", {aux_bus_pull_up, aux_bus_pull_dn}, 20'h00090);
    chk("main pl", {main_bus_pull_up, main_bus_pull_dn}, 16'h00EA);
    wb(1'h0, pfd_pkg::REG_AUX_CFG_HI, 32'h0);
    chk("cfg hi", q[9:0], 10'h376);
    usb_configured <= 1'h1;
    uart_txden <= 1'h1;
    uart_rx_act <= 1'h1;
    step(3);
    chk("power_enable_n on", {power_enable_n, main_bus_pull_up}, 9'h0EA);
    chk("aux act", {aux_bus_out, aux_bus_pull_up}, 20'h4E410);
    wake();
    chk("no wake", pulses, 32'h0);
    usb_suspend <= 1'h1;
    step(3);
    chk("power_enable_n susp", power_enable_n, 1'h1);
    chk("aux susp", aux_bus_out[3:2], 2'h1);
    wake();
    chk("wake", pulses, 32'h1);
    test_done();
  end
endmodule
